// ---- hw/temp_conversion_result_shutdown.sv ----
// Background conversion sequencer with result storage and shutdown control
`timescale 1ns/1ns

// How it works
// (R01) Start converting right after power-up
// (R02) Resolution 9 to 12 bits, default 9
// (R03) Conversion time 150 ms doubling per bit
// (R04) Resolution taken from two select bits
// (R05) Store 16-bit two's-complement result each conversion
// (R06) Top result bit is the sign
// (R07) Result readable anytime, reads never disturb
// (R08) Four lowest result bits read zero
// (R09) Unused low bits below resolution read zero
// (R10) Bit weights 64 down to 1/16 degree
// (R11) Shutdown finishes current conversion, then stands by
// (R12) Shutdown entry clears thermostat in interrupt mode
// (R13) Registers stay reachable during shutdown
// (R14) Writing shutdown bit 0 resumes conversions
// (R15) Mode bit: 0 comparator, 1 interrupt
// (R16) Shutdown bit: 0 run, 1 standby; resets 0
// (R17) Select codes 00..11 map 9..12 bits, next conversion
module temp_conversion_result_shutdown
	import thermo_conv_pkg::*;
#(
	parameter int CYC_PER_MS = CYCLES_PER_MS,
	parameter int CONV_MS_9  = CONV_TIME_9BIT_MS
) (
	input  wire logic                sys_clk_in,
	input  wire logic                rst_in,
	input  wire logic [SENSOR_W-1:0] sensor_code_in,
	input  wire logic                resolution_select_lo_in,
	input  wire logic                resolution_select_hi_in,
	input  wire logic                standby_request_bit_in,
	input  wire logic                thermostat_behaviour_select_in,
	input  wire logic                os_set_in,
	input  wire logic                os_clear_in,
	output logic      [RESULT_W-1:0] temperature_result_out,
	output logic                     conversion_busy_out,
	output logic                     conversion_done_out,
	output logic                     thermostat_active_out
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	// Two states only: converting, or standing by with the last result held
	typedef enum {ST_CONVERT, ST_STANDBY} conv_state_type;

	// Every flop of the block except the check counter cyc_q and the divider count inside u_timebase lives in this one record
	typedef struct packed {
		conv_state_type        state;
		logic [RES_W-1:0]      res;
		logic [MS_CNT_W-1:0]   ms_cnt;
		logic [SENSOR_W-1:0]   samp_s1;
		logic [SENSOR_W-1:0]   samp_s2;
		logic [SENSOR_W-1:0]   samp_s3;
		logic [SENSOR_W-1:0]   samp_ok;
		logic [RESULT_W-1:0]   result;
		logic                  busy;
		logic                  done;
		logic                  os;
	} core_type;

	// Registered record, its next value and the glue logic around it
	core_type              s_q;
	core_type              s_d;
	logic                  tick;
	logic                  restart;
	logic                  end_now;
	logic [RES_W-1:0]      cfg_res;
	logic [MS_CNT_W-1:0]   limit_ms;
	logic [RESULT_W-1:0]   fmt_word;

	// ------------------------------------------------------------
	// Leaf blocks
	// ------------------------------------------------------------
	// One tick per millisecond from the divider; the formatter is pure logic
	ms_timebase #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_timebase (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.restart_in (restart),
		.tick_out   (tick)
	);

	result_formatter u_format (
		.raw_in   (s_q.samp_ok),
		.res_in   (s_q.res),
		.word_out (fmt_word)
	);

	// Select code straight from the two configuration bits
	assign cfg_res  = {resolution_select_hi_in, resolution_select_lo_in}; // R04 R17
	assign limit_ms = conv_limit_ms(CONV_MS_9, s_q.res); // R03
	// A conversion ends on the tick that completes its last millisecond; the
	// divider is realigned at every start, so each conversion lasts exactly
	// limit_ms whole milliseconds, the longest time allowed
	assign end_now  = (s_q.state == ST_CONVERT) && tick && (s_q.ms_cnt == limit_ms - 1'b1);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// The sensor code comes from the analogue side and is several bits wide,
	// so two flops alone could hand over a torn word while it moves. A third
	// stage lets a code through only once two synchronised copies agree; a
	// conversion lasts many milliseconds, so the extra edges never matter
	always_comb begin
		s_d         = s_q;
		s_d.done    = 1'b0;
		restart     = 1'b0;
		s_d.samp_s1 = sensor_code_in;
		s_d.samp_s2 = s_q.samp_s1;
		s_d.samp_s3 = s_q.samp_s2;

		// Only a code that held still for a whole cycle becomes the sample
		if (s_q.samp_s2 == s_q.samp_s3) begin
			s_d.samp_ok = s_q.samp_s2;
		end

		// Thermostat event: set wins over a clear in the same cycle
		if (os_set_in) begin
			s_d.os = 1'b1;
		end else if (os_clear_in) begin
			s_d.os = 1'b0;
		end

		// Conversion end, standby entry and wake-up are all decided here
		case (s_q.state)
			ST_CONVERT: begin
				if (end_now) begin
					s_d.result = fmt_word; // R05 R06
					s_d.done   = 1'b1;
					s_d.ms_cnt = '0;
					// Standby is looked at only here, so a conversion always finishes
					if (standby_request_bit_in) begin
						s_d.state = ST_STANDBY; // R11 R16
						// Interrupt mode drops the output; comparator keeps it
						if (thermostat_behaviour_select_in) begin
							s_d.os = 1'b0; // R12 R15
						end
					end else begin
						s_d.res = cfg_res; // R17
						restart = 1'b1;
					end
				end else if (tick) begin
					s_d.ms_cnt = s_q.ms_cnt + 1'b1;
				end
			end
			ST_STANDBY: begin
				// Result stays readable here; nothing in standby touches it
				if (!standby_request_bit_in) begin
					s_d.state  = ST_CONVERT; // R14
					s_d.res    = cfg_res;
					s_d.ms_cnt = '0;
					restart    = 1'b1;
				end
			end
			// Unreachable codes fall back to a fresh conversion
			default: begin
				s_d.state = ST_CONVERT;
				restart   = 1'b1;
			end
		endcase
		// Busy follows the state that the record is about to hold
		s_d.busy = (s_d.state == ST_CONVERT);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Reset lands directly in a conversion at 9 bits, no host needed
	// The whole record is loaded at once; reset is synchronous like the rest
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			s_q.state   <= ST_CONVERT; // R01
			s_q.res     <= RES_RESET; // R02
			s_q.ms_cnt  <= '0;
			s_q.samp_s1 <= '0;
			s_q.samp_s2 <= '0;
			s_q.samp_s3 <= '0;
			s_q.samp_ok <= '0;
			s_q.result  <= RESULT_RESET;
			s_q.busy    <= 1'b1;
			s_q.done    <= 1'b0;
			s_q.os      <= OS_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state flops; reading is free of side
	// effects, so the host may sample the result in any cycle
	assign temperature_result_out = s_q.result; // R07 R13
	assign conversion_busy_out    = s_q.busy;
	assign conversion_done_out    = s_q.done;
	assign thermostat_active_out  = s_q.os;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Cycle counter since the last conversion start, read only by checks
	// It restarts with the divider, so it counts the cycles of one conversion
	int cyc_q;
	always_ff @(posedge sys_clk_in) begin
		if (rst_in || restart) begin
			cyc_q <= 0;
		end else begin
			cyc_q <= cyc_q + 1;
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	// Named steps of conversion and shutdown, shared by the properties below
	sequence conv_end_s;
		end_now;
	endsequence

	sequence shutdown_req_s;
		conv_end_s ##0 standby_request_bit_in;
	endsequence

	sequence wake_s;
		!conversion_busy_out ##0 !standby_request_bit_in;
	endsequence

	sequence conv_run_s;
		conversion_busy_out ##0 !end_now;
	endsequence

	sequence standby_s;
		!conversion_busy_out ##0 standby_request_bit_in;
	endsequence

	powerup_start_a: assert property ($fell(rst_in) |-> conversion_busy_out && s_q.res == RES_9BIT) // R01
		else $error("no conversion running at 9 bits after reset");

	default_res_a: assert property ($fell(rst_in) |-> limit_ms == MS_CNT_W'(CONV_MS_9)) // R02
		else $error("default conversion length is not the 9-bit time");

	conv_length_a: assert property (conv_end_s |-> cyc_q == int'(limit_ms) * CYC_PER_MS - 1) // R03
		else $error("conversion length does not match resolution");

	res_pickup_a: assert property (conv_end_s ##0 !standby_request_bit_in |=> s_q.res == $past(cfg_res)) // R04
		else $error("next conversion did not take the selected resolution");

	result_only_done_a: assert property ($changed(temperature_result_out) |-> conversion_done_out) // R07
		else $error("result changed outside a conversion end");

	sign_bit_a: assert property (conv_end_s |=> // R06
		temperature_result_out[RESULT_W-1] == $past(s_q.samp_ok[SENSOR_W-1]))
		else $error("result sign bit does not follow the sample");

	low_zero_a: assert property (conversion_done_out |-> // R09
		(temperature_result_out & ~keep_mask($past(s_q.res))) == '0)
		else $error("unused low result bits not zero");

	shutdown_finish_a: assert property (shutdown_req_s |=> !conversion_busy_out && conversion_done_out) // R11
		else $error("shutdown did not follow a completed conversion");

	standby_hold_a: assert property ($fell(conversion_busy_out) |-> $past(end_now)) // R11
		else $error("conversion stopped before it finished");

	os_clear_a: assert property (shutdown_req_s ##0 thermostat_behaviour_select_in |=> !thermostat_active_out) // R12
		else $error("thermostat output not cleared on shutdown in interrupt mode");

	os_keep_a: assert property (shutdown_req_s ##0 !thermostat_behaviour_select_in // R12
		##0 !os_set_in ##0 !os_clear_in |=> $stable(thermostat_active_out))
		else $error("thermostat output changed on shutdown in comparator mode");

	resume_a: assert property (wake_s |=> conversion_busy_out ##0 cyc_q == 0) // R14
		else $error("conversion did not resume after shutdown bit cleared");

	// Resolution and timing
	wake_res_a: assert property (wake_s |=> s_q.res == $past(cfg_res)) // R17
		else $error("wake-up conversion did not take the selected resolution");

	res_steady_a: assert property (conv_run_s |=> $stable(s_q.res)) // R17
		else $error("resolution changed in the middle of a conversion");

	ms_range_a: assert property (s_q.ms_cnt < limit_ms) // R03
		else $error("millisecond count ran past the conversion length");

	// Result word
	done_ends_conv_a: assert property (conversion_done_out |-> $past(conversion_busy_out)) // R05
		else $error("result stored without a conversion behind it");

	done_pulse_a: assert property (conversion_done_out |=> !conversion_done_out) // R05
		else $error("done pulse lasted more than one cycle");

	sample_steady_a: assert property (s_q.samp_s2 == s_q.samp_s3 // R05
		|=> s_q.samp_ok == $past(s_q.samp_s2))
		else $error("settled sensor code not taken as the sample");

	// Standby and thermostat
	standby_idle_a: assert property (standby_s |=> !conversion_busy_out && !conversion_done_out) // R11
		else $error("conversion ran while standby was requested");

	result_hold_a: assert property (standby_s |=> $stable(temperature_result_out)) // R13
		else $error("result changed during standby");

	run_on_zero_a: assert property (conversion_done_out && !$past(standby_request_bit_in) // R16
		|-> conversion_busy_out)
		else $error("conversions stopped with the shutdown bit clear");

	os_set_wins_a: assert property (os_set_in && !(end_now && standby_request_bit_in // R12
		&& thermostat_behaviour_select_in) |=> thermostat_active_out)
		else $error("thermostat set was lost");

endmodule

// ---- hw/thermo_conv_pkg.sv ----
// Shared constants, reset values and helpers for the temperature conversion sequencer
package thermo_conv_pkg;

	// ------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------
	localparam int CLK_HZ            = 10_000_000;
	localparam int MS_PER_S          = 1000;
	// Cycles of sys_clk_in in one millisecond, derived from the clock rate
	localparam int CYCLES_PER_MS     = CLK_HZ / MS_PER_S;
	// Longest conversion at 9 bits, in ms; each extra bit doubles it
	localparam int CONV_TIME_9BIT_MS = 150;

	// ------------------------------------------------------------
	// Widths and field layout
	// ------------------------------------------------------------
	localparam int SENSOR_W   = 12;
	localparam int RESULT_W   = 16;
	localparam int ZERO_LSB_W = 4;
	localparam int RES_W      = 2;
	localparam int MS_CNT_W   = 12;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [RES_W-1:0]    RES_RESET    = 2'h0;
	localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;
	localparam logic                OS_RESET     = 1'b0;

	// ------------------------------------------------------------
	// Resolution codes
	// ------------------------------------------------------------
	localparam logic [RES_W-1:0] RES_9BIT  = 2'h0;
	localparam logic [RES_W-1:0] RES_10BIT = 2'h1;
	localparam logic [RES_W-1:0] RES_11BIT = 2'h2;
	localparam logic [RES_W-1:0] RES_12BIT = 2'h3;

	// Result bits kept for each resolution; the four lowest are always clear
	function automatic logic [RESULT_W-1:0] keep_mask(input logic [RES_W-1:0] res);
		case (res)
			RES_9BIT:  keep_mask = 16'hFF80;
			RES_10BIT: keep_mask = 16'hFFC0;
			RES_11BIT: keep_mask = 16'hFFE0;
			default:   keep_mask = 16'hFFF0;
		endcase
	endfunction

	// Conversion length in ms: base time doubled once per extra bit
	function automatic logic [MS_CNT_W-1:0] conv_limit_ms(input int base_ms,
		input logic [RES_W-1:0] res);
		conv_limit_ms = MS_CNT_W'(base_ms) << res;
	endfunction

endpackage

// ---- hw/ms_timebase.sv ----
// Millisecond tick divider for the conversion timer
`timescale 1ns/1ns
module ms_timebase
	import thermo_conv_pkg::*;
#(
	parameter int CYC_PER_MS = CYCLES_PER_MS
) (
	input  wire logic sys_clk_in,
	input  wire logic rst_in,
	input  wire logic restart_in,
	output logic      tick_out
);
	localparam int CNT_W = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYC_PER_MS - 1);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	// Restart realigns the tick so a conversion lasts whole milliseconds
	always_comb begin
		cnt_d = cnt_q + 1'b1;
		if (restart_in || cnt_q == CNT_LAST) begin
			cnt_d = '0;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Tick must not depend on restart, or the sequencer would form a loop
	assign tick_out = (cnt_q == CNT_LAST);
endmodule

// ---- hw/result_formatter.sv ----
// Packs a raw sensor code into the 16-bit two's-complement result word
`timescale 1ns/1ns
module result_formatter
	import thermo_conv_pkg::*;
(
	input  wire logic [SENSOR_W-1:0] raw_in,
	input  wire logic [RES_W-1:0]    res_in,
	output logic      [RESULT_W-1:0] word_out
);
	// ------------------------------------------------------------
	// Formatting
	// ------------------------------------------------------------
	// Raw code is in 1/16 degree steps, sign at the top; low nibble zero
	assign word_out = {raw_in, ZERO_LSB_W'(0)} & keep_mask(res_in); // R08 R09 R10
endmodule

// ---- testbench/host_model.sv ----
// Host-side model that owns the configuration bits and issues register reads
`timescale 1ns/1ns
module host_model (
	input  wire logic sys_clk_in,
	output logic      resolution_select_lo_out,
	output logic      resolution_select_hi_out,
	output logic      standby_request_bit_out,
	output logic      thermostat_behaviour_select_out,
	output logic      read_pulse_out
);
	// ------------------------------------------------------------
	// Power-up configuration
	// ------------------------------------------------------------
	// Volatile config comes up as 9 bits, running, comparator mode
	initial begin
		resolution_select_lo_out = 1'b0;
		resolution_select_hi_out = 1'b0;
		standby_request_bit_out = 1'b0;
		thermostat_behaviour_select_out = 1'b0;
		read_pulse_out = 1'b0;
	end

	// ------------------------------------------------------------
	// Host accesses
	// ------------------------------------------------------------
	// Configuration write; new bits stand from the next edge on
	task automatic write_config(input logic [1:0] res, input logic sd, input logic tm);
		@(posedge sys_clk_in);
		{resolution_select_hi_out, resolution_select_lo_out} <= res;
		standby_request_bit_out <= sd;
		thermostat_behaviour_select_out <= tm;
	endtask

	// Any register read, which releases the thermostat output
	task automatic read_register();
		@(posedge sys_clk_in);
		read_pulse_out <= 1'b1;
		@(posedge sys_clk_in);
		read_pulse_out <= 1'b0;
	endtask
endmodule

// ---- testbench/tb_temp_conversion_result_shutdown.sv ----
// Self-checking bench for the conversion sequencer and shutdown control
`timescale 1ns/1ns
module tb_temp_conversion_result_shutdown;
	import thermo_conv_pkg::*;
	// Short time base keeps the 12-bit conversion at 240 cycles
	localparam int CPM  = 10;
	localparam int MS9  = 3;
	localparam int LIM9 = CPM * MS9;
	logic                sys_clk_in  = 1'b0;
	logic                rst_in      = 1'b1;
	logic                os_set      = 1'b0;
	logic [SENSOR_W-1:0] sensor_code = 12'h191;
	logic [SENSOR_W-1:0] codes [4]   = '{12'hF5E, 12'hE6F, 12'hC90, 12'h7D0};
	logic                resolution_select_lo, resolution_select_hi;
	logic                standby_request_bit, thermostat_behaviour_select, rd_pulse;
	logic [RESULT_W-1:0] result;
	logic                busy, done, therm;
	int                  errors  = 0;
	int                  n_checks = 0;
	int                  n_done  = 0;
	int                  cur_res = 0;
	int                  n;
	time                 t_last  = 0;

	// ------------------------------------------------------------
	// Clock, instances and done counter
	// ------------------------------------------------------------
	always #50 sys_clk_in = ~sys_clk_in;

	always @(posedge sys_clk_in) begin
		if (done === 1'b1) begin
			n_done <= n_done + 1;
		end
	end

	host_model host (.sys_clk_in(sys_clk_in), .resolution_select_lo_out(resolution_select_lo),
		.resolution_select_hi_out(resolution_select_hi),
		.standby_request_bit_out(standby_request_bit),
		.thermostat_behaviour_select_out(thermostat_behaviour_select),
		.read_pulse_out(rd_pulse));

	temp_conversion_result_shutdown #(.CYC_PER_MS(CPM), .CONV_MS_9(MS9)) uut (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .sensor_code_in(sensor_code),
		.resolution_select_lo_in(resolution_select_lo),
		.resolution_select_hi_in(resolution_select_hi),
		.standby_request_bit_in(standby_request_bit),
		.thermostat_behaviour_select_in(thermostat_behaviour_select),
		.os_set_in(os_set), .os_clear_in(rd_pulse), .temperature_result_out(result),
		.conversion_busy_out(busy), .conversion_done_out(done), .thermostat_active_out(therm));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// Bounded wait for done; returns cycles since the previous mark
	task automatic wait_done(output int cyc);
		int k;
		k = 0;
		do begin
			@(posedge sys_clk_in);
			#1;
			k++;
		end while (done !== 1'b1 && k < 3000);
		if (done !== 1'b1) begin
			errors++;
			$display("mismatch at %0t: no conversion end within the limit", $time);
		end
		cyc = int'(($time - t_last) / 100);
		t_last = $time;
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		chk(16'(busy), 16'h0001, "busy after reset");
		chk(16'(therm), 16'h0000, "thermostat after reset");
		wait_done(n);
		chk(16'(n), 16'(LIM9), "first conversion length");
		chk(result, 16'h1900, "default 9-bit result");
		$display("test reset done");
	endtask

	// New select mid-conversion applies only from the next start; a read disturbs nothing
	task automatic t_res(input logic [1:0] r);
		int prev;
		prev = cur_res;
		wait_done(n);
		host.write_config(r, 1'b0, 1'b0);
		@(posedge sys_clk_in) sensor_code <= codes[r];
		host.read_register();
		wait_done(n);
		chk(16'(n), 16'(LIM9 << prev), "old length kept");
		wait_done(n);
		chk(16'(n), 16'(LIM9 << r), "conversion length");
		chk(result, {codes[r], 4'h0} & (16'hFFF0 << (3 - r)), "result");
		cur_res = r;
		$display("test resolution %0d done", r);
	endtask

	// Shutdown mid-conversion, host access in standby, then wake-up
	task automatic t_stby(input logic tm);
		int lim;
		int seen;
		logic [15:0] held;
		lim = LIM9 << cur_res;
		wait_done(n);
		host.write_config(2'(cur_res), 1'b0, tm);
		@(posedge sys_clk_in) os_set <= 1'b1;
		@(posedge sys_clk_in) os_set <= 1'b0;
		sensor_code <= 12'hFF8;
		#1;
		chk(16'(therm), 16'h0001, "thermostat set");
		host.write_config(2'(cur_res), 1'b1, tm);
		wait_done(n);
		chk(16'(n), 16'(lim), "standby waits for end");
		chk(16'(busy), 16'h0000, "busy in standby");
		chk(result, 16'hFF80, "last result stored");
		chk(16'(therm), 16'(!tm), "thermostat on shutdown");
		held = result;
		// Let the done of the standby entry reach the counter before sampling it
		@(posedge sys_clk_in);
		#1;
		seen = n_done;
		repeat (3 * lim) @(posedge sys_clk_in);
		host.read_register();
		#1;
		chk(16'(therm), 16'h0000, "read in standby");
		chk(16'(n_done - seen), 16'h0000, "no conversion in standby");
		chk(result, held, "result held in standby");
		host.write_config(2'(cur_res), 1'b0, tm);
		t_last = $time;
		wait_done(n);
		chk(16'(n), 16'(lim + 1), "wake-up conversion");
		chk(16'(busy), 16'h0001, "running after wake");
		$display("test standby mode %0d done", tm);
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		#1;
		t_last = $time;
		t_reset();
		for (int i = 0; i < 4; i++) begin
			t_res(2'(i));
		end
		t_stby(1'b1);
		t_stby(1'b0);
		give_verdict();
	end

	// Whole run needs about 4000 cycles; five times that means a hang
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		give_verdict();
	end
endmodule
